// [hdl/ufc_top.sv]
/*
  Endpoint FIFO control: APB register file, four endpoint buffers and the
  byte interface towards the serial interface engine.
  Assumes the engine presents one request per cycle, synchronous to clk_sys_i.
*/
// What this block does
// - Bus reset clears command/status register
// - Clear empties FIFO; next IN forces error
// - Hardware sets setup flag; firmware clears
// - Ready flag reports selected FIFO readiness
// - Zero-length flag set; cleared by data read
// - Redefine bit reapplies configuration, self-clears
// - IN enables for endpoints one to three
// - OUT enables for endpoints; bit zero reads zero
// - Wrong-direction tokens rejected, endpoint stays enabled
// - Mapping field assigns RAM directions
// - Size fields select 8 to 64 bytes
// - Endpoint zero has fixed eight-byte FIFO
// - Disabled endpoint's data port is disabled
`timescale 1ns/1ps
`default_nettype none
module ufc_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 resetn_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  input  wire logic [3:0]           pstrb_i,
  output logic                      pready_o,
  output logic      [31:0]          prdata_o,
  output logic                      pslverr_o,
  input  wire logic                 sie_bus_reset_i,
  input  wire ufc_pkg::ufc_sie_req_type sie_req_i,
  output ufc_pkg::ufc_sie_rsp_type  sie_rsp_o,
  output logic                      irq_o
);
  import ufc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] ep_cap(input logic [1:0] ep, input logic [7:0] sz);
    logic [1:0] code;
    code = 2'h0;
    case (ep)
      2'h1: code = sz[3:2];
      2'h2: code = sz[5:4];
      2'h3: code = sz[7:6];
      default: code = 2'h0;
    endcase
    if (ep == 2'h0) begin
      ep_cap = UFC_EP0_CAP;
    end else begin
      ep_cap = UFC_MIN_CAP << code;
    end
  endfunction

  function automatic logic ep_on(input logic [1:0] ep, input logic [3:1] ien,
                                 input logic [3:1] oen);
    ep_on = (ep == 2'h0) ? 1'b1 : (ien[ep] | oen[ep]);
  endfunction

  ufc_state_type r_reg;
  ufc_state_type r_next;

  logic            wr_en;
  logic            rd_en;
  logic            port_hit;
  logic [1:0]      port_ep;
  logic            ready;
  logic [6:0]      sel_cap;
  logic            in_ok;
  logic            out_ok;
  ufc_ram_map_type ram_map;
  logic [7:0]      cmd_view;

  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign rd_en    = psel_i & penable_i & ~pwrite_i;
  assign port_hit = (paddr_i[11:4] == UFC_DATA_PORT_OFF[11:4]);
  assign port_ep  = paddr_i[3:2];
  assign ram_map  = ufc_ram_map_type'(r_reg.size_map[1:0]);
  // Both-out leaves no RAM for IN pipes, both-in none for OUT pipes
  assign in_ok    = (ram_map != UFC_MAP_BOTH_OUT);
  assign out_ok   = (ram_map != UFC_MAP_BOTH_IN);
  assign sel_cap  = ep_cap(r_reg.ep_sel, r_reg.size_act);

  // Write access needs room, read access needs data
  assign ready = r_reg.cmd[UFC_REQ_BIT]
               & ep_on(r_reg.ep_sel, r_reg.in_en, r_reg.out_en)
               & (r_reg.cmd[UFC_DIR_BIT]
                  ? (r_reg.wr_idx[r_reg.ep_sel] < sel_cap)
                  : (r_reg.wr_idx[r_reg.ep_sel] != r_reg.rd_idx[r_reg.ep_sel]));

  always_comb begin
    cmd_view = r_reg.cmd;
    cmd_view[UFC_READY_BIT] = ready;
    cmd_view[4:3] = 2'h0;
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  assign pready_o = psel_i & penable_i;

  always_comb begin
    prdata_o  = 32'h0000_0000;
    pslverr_o = 1'b0;
    if (port_hit) begin
      if (!ep_on(port_ep, r_reg.in_en, r_reg.out_en)) begin
        pslverr_o = pready_o;
      end else if (!pwrite_i && r_reg.wr_idx[port_ep] != r_reg.rd_idx[port_ep]) begin
        prdata_o[7:0] = r_reg.mem[port_ep][r_reg.rd_idx[port_ep][5:0]];
      end
    end else begin
      case (paddr_i)
        UFC_CMD_STATUS_OFF: prdata_o[7:0] = cmd_view;
        UFC_IN_PIPE_OFF:    prdata_o[7:0] = {4'h0, r_reg.in_en, r_reg.redefine};
        UFC_OUT_PIPE_OFF:   prdata_o[7:0] = {4'h0, r_reg.out_en, 1'b0};
        UFC_SIZE_MAP_OFF:   prdata_o[7:0] = r_reg.size_map;
        UFC_IRQ_STAT_OFF:   prdata_o[UFC_IRQ_W-1:0] = r_reg.irq_stat;
        UFC_IRQ_MASK_OFF:   prdata_o[UFC_IRQ_W-1:0] = r_reg.irq_mask;
        UFC_EP_SELECT_OFF:  prdata_o[1:0] = r_reg.ep_sel;
        default:            pslverr_o = pready_o;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] ep;
    logic [6:0] cap;
    ep  = 2'h0;
    cap = 7'h00;
    r_next = r_reg;
    r_next.rsp = '0;

    // Configuration takes effect one cycle after the redefine write
    if (r_reg.redefine) begin
      r_next.redefine = 1'b0;
      r_next.size_act = r_reg.size_map;
      for (int i = 1; i < UFC_NUM_EP; i++) begin
        r_next.wr_idx[i] = '0;
        r_next.rd_idx[i] = '0;
      end
    end

    // Firmware side first so that hardware events win
    if (wr_en && pstrb_i[0]) begin
      if (port_hit) begin
        if (ep_on(port_ep, r_reg.in_en, r_reg.out_en)
            && r_next.wr_idx[port_ep] < ep_cap(port_ep, r_reg.size_act)) begin
          r_next.mem[port_ep][r_next.wr_idx[port_ep][5:0]] = pwdata_i[7:0];
          r_next.wr_idx[port_ep] = r_next.wr_idx[port_ep] + 7'h01;
        end
      end else begin
        case (paddr_i)
          UFC_CMD_STATUS_OFF: begin
            r_next.cmd[UFC_REQ_BIT]   = pwdata_i[UFC_REQ_BIT];
            r_next.cmd[UFC_DIR_BIT]   = pwdata_i[UFC_DIR_BIT];
            r_next.cmd[UFC_CLEAR_BIT] = pwdata_i[UFC_CLEAR_BIT];
            r_next.cmd[UFC_SETUP_BIT] = r_reg.cmd[UFC_SETUP_BIT]
                                      & pwdata_i[UFC_SETUP_BIT];
            if (pwdata_i[UFC_CLEAR_BIT]) begin
              r_next.wr_idx[r_reg.ep_sel]   = '0;
              r_next.rd_idx[r_reg.ep_sel]   = '0;
              r_next.underrun[r_reg.ep_sel] = 1'b1;
            end
          end
          UFC_IN_PIPE_OFF: begin
            r_next.redefine = pwdata_i[UFC_REDEFINE_BIT];
            r_next.in_en    = pwdata_i[3:1];
          end
          UFC_OUT_PIPE_OFF:  r_next.out_en   = pwdata_i[3:1];
          UFC_SIZE_MAP_OFF:  r_next.size_map = pwdata_i[7:0];
          UFC_IRQ_STAT_OFF:  r_next.irq_stat = r_reg.irq_stat & ~pwdata_i[UFC_IRQ_W-1:0];
          UFC_IRQ_MASK_OFF:  r_next.irq_mask = pwdata_i[UFC_IRQ_W-1:0];
          UFC_EP_SELECT_OFF: r_next.ep_sel   = pwdata_i[1:0];
          default: ;
        endcase
      end
    end

    if (rd_en && port_hit && ep_on(port_ep, r_reg.in_en, r_reg.out_en)) begin
      r_next.cmd[UFC_ZLEN_BIT] = 1'b0;
      if (r_next.wr_idx[port_ep] != r_next.rd_idx[port_ep]) begin
        r_next.rd_idx[port_ep] = r_next.rd_idx[port_ep] + 7'h01;
        if (r_next.rd_idx[port_ep] == r_next.wr_idx[port_ep]) begin
          r_next.wr_idx[port_ep] = '0;
          r_next.rd_idx[port_ep] = '0;
        end
      end
    end

    // Engine side
    ep  = sie_req_i.ep;
    cap = ep_cap(ep, r_reg.size_act);
    if (sie_req_i.in_req) begin
      if (ep != 2'h0 && !(r_reg.in_en[ep] && in_ok)) begin
        r_next.rsp.reject = 1'b1;
        r_next.irq_stat[UFC_IRQ_REJECT] = 1'b1;
      end else if (r_next.underrun[ep]) begin
        r_next.rsp.force_err = 1'b1;
        r_next.underrun[ep]  = 1'b0;
        r_next.irq_stat[UFC_IRQ_UNDERRUN] = 1'b1;
      end else if (r_next.wr_idx[ep] != r_next.rd_idx[ep]) begin
        r_next.rsp.valid = 1'b1;
        r_next.rsp.data  = r_next.mem[ep][r_next.rd_idx[ep][5:0]];
        r_next.rd_idx[ep] = r_next.rd_idx[ep] + 7'h01;
        if (r_next.rd_idx[ep] == r_next.wr_idx[ep]) begin
          r_next.wr_idx[ep] = '0;
          r_next.rd_idx[ep] = '0;
        end
      end
    end

    if (sie_req_i.out_byte) begin
      if (ep != 2'h0 && !(r_reg.out_en[ep] && out_ok)) begin
        r_next.rsp.reject = 1'b1;
        r_next.irq_stat[UFC_IRQ_REJECT] = 1'b1;
      end else if (r_next.wr_idx[ep] < cap) begin
        r_next.mem[ep][r_next.wr_idx[ep][5:0]] = sie_req_i.data;
        r_next.wr_idx[ep] = r_next.wr_idx[ep] + 7'h01;
        r_next.underrun[ep] = 1'b0;
        r_next.got_byte = 1'b1;
      end
    end

    if (sie_req_i.pkt_end) begin
      if (sie_req_i.setup) begin
        r_next.cmd[UFC_SETUP_BIT] = 1'b1;
        r_next.irq_stat[UFC_IRQ_SETUP] = 1'b1;
      end
      if (!(r_reg.got_byte || sie_req_i.out_byte)) begin
        r_next.cmd[UFC_ZLEN_BIT] = 1'b1;
        r_next.irq_stat[UFC_IRQ_ZLEN] = 1'b1;
      end else begin
        r_next.irq_stat[UFC_IRQ_OUT_DONE] = 1'b1;
      end
      r_next.got_byte = 1'b0;
    end

    // A bus reset ends any transfer in flight
    if (sie_bus_reset_i) begin
      r_next.cmd      = UFC_CMD_RESET;
      r_next.wr_idx   = '0;
      r_next.rd_idx   = '0;
      r_next.underrun = '0;
      r_next.got_byte = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sie_rsp_o = r_reg.rsp;
  assign irq_o     = |(r_reg.irq_stat & r_reg.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_bus_reset_cmd: assert property (sie_bus_reset_i |=> r_reg.cmd == UFC_CMD_RESET)
    else $error("command register not cleared by bus reset");

  a_clear_empties: assert property (wr_en && pstrb_i[0] && paddr_i == UFC_CMD_STATUS_OFF
      && pwdata_i[UFC_CLEAR_BIT] && !port_hit && !sie_bus_reset_i
      && !(sie_req_i.out_byte && sie_req_i.ep == r_reg.ep_sel)
      |=> r_reg.underrun[$past(r_reg.ep_sel)] && r_reg.wr_idx[$past(r_reg.ep_sel)] == 7'h00)
    else $error("clear did not empty the selected buffer");

  a_underrun_err: assert property (sie_req_i.in_req && r_reg.underrun[sie_req_i.ep]
      && !sie_bus_reset_i && (sie_req_i.ep == 2'h0 || (r_reg.in_en[sie_req_i.ep] && in_ok))
      |=> sie_rsp_o.force_err && !sie_rsp_o.valid)
    else $error("underrun not signalled on IN");

  a_setup_flag: assert property (sie_req_i.pkt_end && sie_req_i.setup && !sie_bus_reset_i
      |=> r_reg.cmd[UFC_SETUP_BIT])
    else $error("setup flag not set");

  a_ready_needs: assert property (ready |-> r_reg.cmd[UFC_REQ_BIT]
      && ep_on(r_reg.ep_sel, r_reg.in_en, r_reg.out_en))
    else $error("ready without request");

  a_zero_len: assert property (sie_req_i.pkt_end && !r_reg.got_byte && !sie_req_i.out_byte
      && !sie_bus_reset_i |=> r_reg.cmd[UFC_ZLEN_BIT])
    else $error("zero-length flag not set");

  a_redefine_pulse: assert property (wr_en && pstrb_i[0] && paddr_i == UFC_IN_PIPE_OFF
      && pwdata_i[UFC_REDEFINE_BIT] |=> r_reg.redefine ##1 !r_reg.redefine
      && r_reg.size_act == $past(r_reg.size_map))
    else $error("redefine not applied and cleared");

  a_reject_token: assert property (sie_req_i.in_req && sie_req_i.ep != 2'h0
      && !r_reg.in_en[sie_req_i.ep] |=> sie_rsp_o.reject && !sie_rsp_o.valid)
    else $error("wrong-direction token not rejected");

  a_ep0_cap: assert property (r_reg.wr_idx[0] <= UFC_EP0_CAP)
    else $error("endpoint zero buffer overrun");

  a_size_cap: assert property (!r_reg.redefine |-> r_reg.wr_idx[1]
      <= ep_cap(2'h1, r_reg.size_act))
    else $error("endpoint one buffer overrun");

  a_out_pipe_read: assert property (rd_en && paddr_i == UFC_OUT_PIPE_OFF
      |-> prdata_o[7:4] == 4'h0 && !prdata_o[0] && prdata_o[3:1] == r_reg.out_en)
    else $error("out pipe enable read back wrongly");

  a_both_out_in: assert property (sie_req_i.in_req && sie_req_i.ep != 2'h0
      && ram_map == UFC_MAP_BOTH_OUT |=> sie_rsp_o.reject && !sie_rsp_o.valid)
    else $error("IN token accepted with both buffers outbound");

  a_both_in_out: assert property (sie_req_i.out_byte && sie_req_i.ep != 2'h0
      && ram_map == UFC_MAP_BOTH_IN |=> sie_rsp_o.reject)
    else $error("OUT byte accepted with both buffers inbound");

  a_port_disabled: assert property (wr_en && port_hit
      && !ep_on(port_ep, r_reg.in_en, r_reg.out_en) && !r_reg.redefine && !sie_bus_reset_i
      |=> r_reg.wr_idx[$past(port_ep)] == $past(r_reg.wr_idx[port_ep]))
    else $error("disabled data port accepted a byte");

  // An engine IN may pop the same buffer in that cycle, so those cycles are left out
  a_port_pop: assert property (rd_en && port_hit
      && ep_on(port_ep, r_reg.in_en, r_reg.out_en) && !r_reg.redefine && !sie_bus_reset_i
      && r_reg.wr_idx[port_ep] > r_reg.rd_idx[port_ep] + 7'h01
      && !(sie_req_i.in_req && sie_req_i.ep == port_ep)
      |=> r_reg.rd_idx[$past(port_ep)] == $past(r_reg.rd_idx[port_ep]) + 7'h01)
    else $error("data port read did not advance one byte");

  a_port_push: assert property (wr_en && pstrb_i[0] && port_hit
      && ep_on(port_ep, r_reg.in_en, r_reg.out_en) && !r_reg.redefine && !sie_bus_reset_i
      && r_reg.wr_idx[port_ep] < ep_cap(port_ep, r_reg.size_act)
      && !(sie_req_i.ep == port_ep && (sie_req_i.in_req || sie_req_i.out_byte))
      |=> r_reg.wr_idx[$past(port_ep)] == $past(r_reg.wr_idx[port_ep]) + 7'h01
      && r_reg.mem[$past(port_ep)][$past(r_reg.wr_idx[port_ep][5:0])] == $past(pwdata_i[7:0]))
    else $error("data port write did not store one byte");

  a_zlen_cleared: assert property (rd_en && port_hit
      && ep_on(port_ep, r_reg.in_en, r_reg.out_en) && !sie_req_i.pkt_end
      |=> !r_reg.cmd[UFC_ZLEN_BIT])
    else $error("zero-length flag kept after data read");

  a_ep0_port_on: assert property (psel_i && penable_i
      && paddr_i == UFC_DATA_PORT_OFF |-> !pslverr_o)
    else $error("endpoint zero data port refused");

  a_reject_irq: assert property (sie_req_i.in_req && sie_req_i.ep != 2'h0
      && !r_reg.in_en[sie_req_i.ep] |=> r_reg.irq_stat[UFC_IRQ_REJECT])
    else $error("rejected token not flagged");

  a_reject_keeps: assert property (sie_req_i.in_req && sie_req_i.ep != 2'h0
      && !r_reg.in_en[sie_req_i.ep] && !wr_en
      |=> r_reg.out_en == $past(r_reg.out_en) && r_reg.in_en == $past(r_reg.in_en))
    else $error("rejected token changed the pipe enables");

endmodule
`default_nettype wire

// [hdl/ufc_pkg.sv]
/*
  Constants, carriers and the state record of the USB endpoint FIFO control.
  Assumes one 250 MHz system clock and an APB bus with 32-bit data.
*/
package ufc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned UFC_NUM_EP  = 4;
  localparam int unsigned UFC_DEPTH   = 64;
  localparam int unsigned UFC_IDX_W   = 7;
  localparam int unsigned UFC_IRQ_W   = 5;
  localparam logic [6:0]  UFC_EP0_CAP = 7'h08;
  localparam logic [6:0]  UFC_MIN_CAP = 7'h08;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] UFC_CMD_STATUS_OFF = 12'h000;
  localparam logic [11:0] UFC_IN_PIPE_OFF    = 12'h004;
  localparam logic [11:0] UFC_OUT_PIPE_OFF   = 12'h008;
  localparam logic [11:0] UFC_SIZE_MAP_OFF   = 12'h00C;
  localparam logic [11:0] UFC_DATA_PORT_OFF  = 12'h010;
  localparam logic [11:0] UFC_IRQ_STAT_OFF   = 12'h020;
  localparam logic [11:0] UFC_IRQ_MASK_OFF   = 12'h024;
  localparam logic [11:0] UFC_EP_SELECT_OFF  = 12'h028;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned UFC_REQ_BIT      = 0;
  localparam int unsigned UFC_DIR_BIT      = 1;
  localparam int unsigned UFC_CLEAR_BIT    = 2;
  localparam int unsigned UFC_SETUP_BIT    = 5;
  localparam int unsigned UFC_READY_BIT    = 6;
  localparam int unsigned UFC_ZLEN_BIT     = 7;
  localparam int unsigned UFC_REDEFINE_BIT = 0;
  localparam int unsigned UFC_IRQ_SETUP    = 0;
  localparam int unsigned UFC_IRQ_ZLEN     = 1;
  localparam int unsigned UFC_IRQ_OUT_DONE = 2;
  localparam int unsigned UFC_IRQ_UNDERRUN = 3;
  localparam int unsigned UFC_IRQ_REJECT   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UFC_CMD_RESET      = 8'h00;
  localparam logic [7:0] UFC_SIZE_MAP_RESET = 8'h00;
  localparam logic [3:1] UFC_PIPE_RESET     = 3'h0;

  typedef enum logic [1:0] {
    UFC_MAP_IN_OUT   = 2'h0,
    UFC_MAP_BOTH_OUT = 2'h1,
    UFC_MAP_BOTH_IN  = 2'h2,
    UFC_MAP_OUT_IN   = 2'h3
  } ufc_ram_map_type;

  // ----------------------------------------------------------------
  // Link carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       in_req;
    logic       out_byte;
    logic       pkt_end;
    logic       setup;
    logic [1:0] ep;
    logic [7:0] data;
  } ufc_sie_req_type;

  typedef struct packed {
    logic       valid;
    logic       force_err;
    logic       reject;
    logic [7:0] data;
  } ufc_sie_rsp_type;

  typedef struct packed {
    logic [7:0]                                   cmd;
    logic                                         redefine;
    logic [3:1]                                   in_en;
    logic [3:1]                                   out_en;
    logic [7:0]                                   size_map;
    logic [7:0]                                   size_act;
    logic [1:0]                                   ep_sel;
    logic [UFC_IRQ_W-1:0]                         irq_stat;
    logic [UFC_IRQ_W-1:0]                         irq_mask;
    logic [UFC_NUM_EP-1:0][UFC_IDX_W-1:0]         wr_idx;
    logic [UFC_NUM_EP-1:0][UFC_IDX_W-1:0]         rd_idx;
    logic [UFC_NUM_EP-1:0]                        underrun;
    logic                                         got_byte;
    logic [UFC_NUM_EP-1:0][UFC_DEPTH-1:0][7:0]    mem;
    ufc_sie_rsp_type                              rsp;
  } ufc_state_type;

endpackage

// [testbench/ufc_sie_model.sv]
/*
  Host-side model of the serial engine's byte requests.
  Assumes callers enter its tasks right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_sie_model
  import ufc_pkg::*;
(
  input  wire logic                 clk_sys_i,
  output var ufc_pkg::ufc_sie_req_type req_o
);
  initial req_o = '0;
  // Flags are {in, out byte, end, setup}; held for one sampling edge
  task automatic send(input logic [3:0] f, input logic [1:0] ep, input logic [7:0] d);
    req_o <= {f, ep, d};
    @(posedge clk_sys_i);
  endtask
  // Idle data flips so a stale byte never looks live
  task automatic rest();
    req_o <= {6'h00, ~req_o.data};
    @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
/*
  Self-checking bench of the endpoint FIFO control.
  Assumes zero-wait APB answers and engine responses one cycle after a token.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ufc_pkg::*;
  typedef struct packed { logic [32:0] v; logic [32:0] m; } ufc_note_type;
  localparam logic [3:0]  F_IN = 4'h8, F_OUT = 4'h4, F_END = 4'h2, F_SET = 4'h1;
  localparam logic [10:0] RSP_OK = 11'h400, RSP_ERR = 11'h200, RSP_REJ = 11'h100;
  localparam logic [10:0] RSP_MASK = 11'h700;
  localparam logic [32:0] ERR = 33'h100000000;
  logic            clk_sys_i = 1'b0, resetn_i = 1'b0, bus_rst = 1'b0;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0, prdata, lfsr = 32'hB5D9;
  logic [7:0]      b [64];
  ufc_sie_req_type req;
  ufc_sie_rsp_type rsp;
  ufc_note_type    apb_q [$], sie_q [$];
  int              miscompares = 0, check_count = 0;

  always #2 clk_sys_i = ~clk_sys_i;
  ufc_top i_ufc_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .sie_bus_reset_i(bus_rst), .sie_req_i(req), .sie_rsp_o(rsp), .irq_o(irq));
  ufc_sie_model i_ufc_sie_model (.clk_sys_i(clk_sys_i), .req_o(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic cmp(input logic [32:0] got, input ufc_note_type n);
    check_count++;
    if ((got & n.m) !== (n.v & n.m)) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got & n.m, n.v & n.m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m = '1);
    apb_q.push_back(ufc_note_type'{v: e, m: m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tok(input logic [3:0] f, input logic [1:0] ep, input logic [7:0] d,
                     input logic [10:0] e, input logic [10:0] m);
    if (m != 11'h0) sie_q.push_back(ufc_note_type'{v: {22'h0, e}, m: {22'h0, m}});
    i_ufc_sie_model.send(f, ep, d);
    i_ufc_sie_model.rest();
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk_sys_i);
    cmp({32'h0, irq}, ufc_note_type'{v: {32'h0, e}, m: '1});
  endtask
  task automatic report_and_stop();
    if (sie_q.size() != 0) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, 11'h0, sie_q[0].v);
    end
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Results are matched in arrival order; an unannounced response fails
  always @(posedge clk_sys_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp({pslverr, prdata}, apb_q.pop_front());
    end
    if (resetn_i && (rsp.valid | rsp.force_err | rsp.reject) !== 1'b0) begin
      cmp({22'h0, rsp}, sie_q.size() > 0 ? sie_q.pop_front() : ufc_note_type'{v: '0, m: '1});
    end
  end
  initial begin
    #80000;
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(UFC_CMD_STATUS_OFF, '0);
    rd(UFC_IN_PIPE_OFF, '0);
    rd(UFC_OUT_PIPE_OFF, '0);
    rd(UFC_SIZE_MAP_OFF, '0);
    rd(UFC_DATA_PORT_OFF + 12'hC, ERR, ERR);
    wr(UFC_DATA_PORT_OFF + 12'hC, 32'h11);
    rd(12'h030, ERR, ERR);
    wr(UFC_OUT_PIPE_OFF, 32'hF);
    wr(UFC_IN_PIPE_OFF, 32'hF);
    rd(UFC_IN_PIPE_OFF, 33'hE);
    rd(UFC_OUT_PIPE_OFF, 33'hE);
    wr(UFC_EP_SELECT_OFF, 32'h1);
    // Fill to the exact size boundary, then drain back to back
    for (int c = 0; c < 4; c++) begin
      wr(UFC_SIZE_MAP_OFF, 32'(c << 2));
      wr(UFC_IN_PIPE_OFF, 32'hF);
      wr(UFC_CMD_STATUS_OFF, 32'h3);
      for (int i = 0; i < (8 << c); i++) begin
        if (i == (8 << c) - 1) rd(UFC_CMD_STATUS_OFF, 33'h43);
        b[i] = rnd();
        wr(UFC_DATA_PORT_OFF + 12'h4, {24'h0, b[i]});
      end
      wr(UFC_DATA_PORT_OFF + 12'h4, 32'hA5);
      rd(UFC_CMD_STATUS_OFF, 33'h03);
      wr(UFC_CMD_STATUS_OFF, 32'h1);
      wr(UFC_CMD_STATUS_OFF, 32'h0);
      for (int i = 0; i < (8 << c); i++) begin
        sie_q.push_back(ufc_note_type'{v: {22'h0, RSP_OK | 11'(b[i])}, m: '1});
        i_ufc_sie_model.send(F_IN, 2'h1, 8'h00);
      end
      tok(F_IN, 2'h1, 8'h00, 11'h0, 11'h0);
    end
    for (int i = 0; i < 3; i++) begin
      b[i] = rnd();
      i_ufc_sie_model.send(F_OUT, 2'h1, b[i]);
    end
    tok(F_END, 2'h1, 8'h00, 11'h0, 11'h0);
    irq_is(1'b0);
    wr(UFC_IRQ_MASK_OFF, 32'h4);
    irq_is(1'b1);
    rd(UFC_IRQ_STAT_OFF, 33'h04);
    wr(UFC_CMD_STATUS_OFF, 32'h1);
    rd(UFC_CMD_STATUS_OFF, 33'h41);
    for (int i = 0; i < 3; i++) rd(UFC_DATA_PORT_OFF + 12'h4, {25'h0, b[i]});
    rd(UFC_CMD_STATUS_OFF, 33'h01);
    wr(UFC_CMD_STATUS_OFF, 32'h3);
    wr(UFC_CMD_STATUS_OFF, 32'h0);
    wr(UFC_IRQ_STAT_OFF, 32'h4);
    irq_is(1'b0);
    // Every mapping code; the leftover byte of code 01 drains under 00
    for (int i = 0; i < 4; i++) b[i] = rnd();
    wr(UFC_SIZE_MAP_OFF, 32'h1);
    tok(F_OUT, 2'h1, b[0], 11'h0, 11'h0);
    tok(F_IN, 2'h1, 8'h00, RSP_REJ, RSP_MASK);
    wr(UFC_SIZE_MAP_OFF, 32'h0);
    tok(F_OUT, 2'h1, b[1], 11'h0, 11'h0);
    tok(F_IN, 2'h1, 8'h00, RSP_OK | 11'(b[0]), '1);
    tok(F_IN, 2'h1, 8'h00, RSP_OK | 11'(b[1]), '1);
    wr(UFC_SIZE_MAP_OFF, 32'h3);
    tok(F_OUT, 2'h1, b[2], 11'h0, 11'h0);
    tok(F_IN, 2'h1, 8'h00, RSP_OK | 11'(b[2]), '1);
    wr(UFC_SIZE_MAP_OFF, 32'h2);
    tok(F_OUT, 2'h1, b[3], RSP_REJ, RSP_MASK);
    tok(F_IN, 2'h1, 8'h00, 11'h0, 11'h0);
    wr(UFC_SIZE_MAP_OFF, 32'h0);
    wr(UFC_IN_PIPE_OFF, 32'hC);
    tok(F_IN, 2'h1, 8'h00, RSP_REJ, RSP_MASK);
    tok(F_OUT | F_END, 2'h1, b[3], 11'h0, 11'h0);
    wr(UFC_CMD_STATUS_OFF, 32'h1);
    rd(UFC_DATA_PORT_OFF + 12'h4, {25'h0, b[3]});
    wr(UFC_EP_SELECT_OFF, 32'h2);
    wr(UFC_CMD_STATUS_OFF, 32'h3);
    wr(UFC_DATA_PORT_OFF + 12'h8, 32'h5A);
    wr(UFC_CMD_STATUS_OFF, 32'h5);
    wr(UFC_CMD_STATUS_OFF, 32'h0);
    tok(F_IN, 2'h2, 8'h00, RSP_ERR, RSP_MASK);
    tok(F_IN, 2'h2, 8'h00, 11'h0, 11'h0);
    wr(UFC_EP_SELECT_OFF, 32'h0);
    tok(F_END, 2'h0, 8'h00, 11'h0, 11'h0);
    rd(UFC_CMD_STATUS_OFF, 33'h80);
    rd(UFC_DATA_PORT_OFF, 33'h0);
    rd(UFC_CMD_STATUS_OFF, 33'h0);
    // First flag cleared by firmware, second by a bus reset
    for (int k = 0; k < 2; k++) begin
      i_ufc_sie_model.send(F_OUT, 2'h0, rnd());
      tok(F_END | F_SET, 2'h0, 8'h00, 11'h0, 11'h0);
      rd(UFC_CMD_STATUS_OFF, 33'h20);
      if (k == 0) begin
        wr(UFC_CMD_STATUS_OFF, 32'h0);
      end else begin
        bus_rst <= 1'b1;
        @(posedge clk_sys_i);
        bus_rst <= 1'b0;
        @(posedge clk_sys_i);
      end
      rd(UFC_CMD_STATUS_OFF, 33'h0);
    end
    wr(UFC_CMD_STATUS_OFF, 32'h3);
    for (int i = 0; i < 8; i++) wr(UFC_DATA_PORT_OFF, 32'(i));
    rd(UFC_CMD_STATUS_OFF, 33'h03);
    report_and_stop();
  end
endmodule
`default_nettype wire
